//--- hdl/tts_cfg.svh
// Constants for the thermometer and thermostat core
`ifndef TTS_CFG_SVH
`define TTS_CFG_SVH
`define TTS_TEMP_RST      12'hc40
`define TTS_UPPER_FACT    12'h0f0
`define TTS_LOWER_FACT    12'h0a0
`define TTS_CFG_HI_RST    4'h8
`define TTS_CFG_LO_FACT   4'h0
`define TTS_CLK_MHZ       125
`define TTS_CONV_MS       750
`define TTS_NVW_MS        10
`define TTS_CMD_RD_TEMP   8'haa
`define TTS_CMD_RD_UP     8'ha1
`define TTS_CMD_RD_LO     8'ha2
`define TTS_CMD_RD_CFG    8'hac
`define TTS_CMD_WR_UP     8'h01
`define TTS_CMD_WR_LO     8'h02
`define TTS_CMD_WR_CFG    8'h0c
`define TTS_CMD_START     8'h51
`define TTS_CMD_STOP      8'h22
`define TTS_CFG_DONE_BIT  7
`define TTS_CFG_NVB_BIT   4
`define TTS_CFG_SA_BIT    0
`define TTS_CFG_RES_LSB   2
`endif

//--- hdl/tts_pkg.sv
// Types for the thermometer and thermostat core
package tts_pkg;
   // Result of a completed serial frame
   typedef struct packed {
      logic       valid;
      logic [7:0] cmd;
      logic [11:0] data;
   } tts_frame_s;
   // Thermostat output bundle
   typedef struct packed {
      logic upper;
      logic lower;
      logic comb;
   } tts_trip_s;
   typedef enum logic [1:0] {TTS_IDLE, TTS_CONV, TTS_NVW} tts_state_e;
endpackage : tts_pkg

//--- hdl/tts_core.sv
// Thermometer and thermostat core with three-wire link
`include "tts_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tts_core #(
   parameter int CONV_CYC = `TTS_CONV_MS * `TTS_CLK_MHZ * 1000,   // Longest 12-bit conversion
   parameter int NVW_CYC  = `TTS_NVW_MS * `TTS_CLK_MHZ * 1000     // Nonvolatile write time
) (
   input  wire logic        sys_clk_i,           // System clock
   input  wire logic        rst_n_i,             // Synchronous reset, low
   input  wire logic        serial_clock_convert_i, // Link clock, also convert control
   input  wire logic        link_rst_n_i,        // Link frame enable, low idles link
   input  wire logic        dq_i,                // Serial data in
   output logic             dq_o,                // Serial data out
   output logic             dq_oe_o,             // Data drive enable
   input  wire logic [11:0] sense_i,             // Raw sensor sample, signed
   output logic             trip_upper_o,        // Upper trip output
   output logic             trip_lower_o,        // Lower trip output
   output logic             trip_comb_o,         // Combined hysteresis output
   output logic             busy_o               // Conversion or write in progress
);
   //--------------------------------------------------------------
   // Link domain
   //--------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  cnt;     // Bit counter within frame
      logic [7:0]  cmd;     // Command shift
      logic [11:0] dat;     // Data shift in
      logic [11:0] sh;      // Data shift out
      logic        tog;     // Toggles at command byte end and at data end
      logic [7:0]  cmd_h;   // Held command
      logic [11:0] dat_h;   // Held data
   } tts_link_s;
   tts_link_s lk_r, lk_nxt;
   logic       dq_out_r;    // Output bit, falling edge
   logic       dq_en_r;     // Output enable, falling edge
   logic [11:0] rd_word;    // Read word chosen in link domain
   // Shadow words from system domain, stable during frames
   logic [11:0] shd_temp_r, shd_up_r, shd_lo_r;
   logic [7:0]  shd_cfg_r;
   //--------------------------------------------------------------
   // Read mux on the held copies
   //--------------------------------------------------------------
   always_comb begin
      // Last command bit arrives on the same edge that loads the read word
      case ({dq_i, lk_r.cmd[7:1]})
         `TTS_CMD_RD_TEMP: rd_word = shd_temp_r;
         `TTS_CMD_RD_UP:   rd_word = shd_up_r;
         `TTS_CMD_RD_LO:   rd_word = shd_lo_r;
         `TTS_CMD_RD_CFG:  rd_word = {4'h0, shd_cfg_r};
         default:          rd_word = 12'h000;
      endcase
   end
   //--------------------------------------------------------------
   // Shift logic, link rising edge
   //--------------------------------------------------------------
   always_comb begin
      lk_nxt = lk_r;
      if (!link_rst_n_i) begin
         lk_nxt.cnt = 5'h00;
      end else if (lk_r.cnt < 5'h08) begin
         lk_nxt.cmd = {dq_i, lk_r.cmd[7:1]};            // LSB first
         lk_nxt.cnt = lk_r.cnt + 5'h01;
         if (lk_r.cnt == 5'h07) begin
            lk_nxt.cmd_h = {dq_i, lk_r.cmd[7:1]};       // Held until next frame
            lk_nxt.sh = rd_word;
            lk_nxt.tog = ~lk_r.tog;
         end
      end else if (lk_r.cnt < 5'h14) begin
         lk_nxt.dat = {dq_i, lk_r.dat[11:1]};
         lk_nxt.sh  = {1'b0, lk_r.sh[11:1]};
         lk_nxt.cnt = lk_r.cnt + 5'h01;
         if (lk_r.cnt == 5'h13) begin
            lk_nxt.dat_h = {dq_i, lk_r.dat[11:1]};      // Held until next frame
            lk_nxt.tog = ~lk_r.tog;                     // Write data complete
         end
      end
   end
   // Link clock stops between frames; frame held via async release of enable
   // Closed link clears the frame at once, so a cut frame cannot linger
   always_ff @(posedge serial_clock_convert_i or negedge link_rst_n_i) begin
      if (!link_rst_n_i) begin
         lk_r.cnt <= 5'h00;
         lk_r.tog <= 1'b0;
      end else begin
         lk_r <= lk_nxt;
      end
   end
   //--------------------------------------------------------------
   // Data drive on falling edge, only in read data phase
   //--------------------------------------------------------------
   // dq_en_r drops as soon as the link closes, even in a cut frame; dq_oe_o drops three system clocks later
   always_ff @(negedge serial_clock_convert_i or negedge link_rst_n_i) begin
      if (!link_rst_n_i) begin
         dq_out_r <= 1'b0;
         dq_en_r  <= 1'b0;
      end else begin
         dq_out_r <= lk_r.sh[0];
         dq_en_r  <= lk_r.cnt >= 5'h08 && lk_r.cnt < 5'h14
                     && lk_r.cmd[7];
      end
   end
   //--------------------------------------------------------------
   // System domain: crossing
   //--------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  tog_s;   // Toggle synchroniser and edge stage
      logic [1:0]  en_s;    // Link enable synchroniser
      logic [1:0]  clk_s;   // Convert pin synchroniser
      logic [1:0]  oe_s;    // Drive enable synchroniser
      logic [1:0]  do_s;    // Data out synchroniser
      logic        clk_d;   // Previous convert level
      logic        seen;    // Command byte taken
      logic [7:0]  cmd;     // Pending command
      logic [11:0] temp;    // Result
      logic [11:0] up;      // Upper threshold
      logic [11:0] lo;      // Lower threshold
      logic [3:0]  cfg_hi;  // Volatile config bits
      logic [3:0]  cfg_lo;  // Nonvolatile config bits
      logic        run;     // Continuous conversion enabled
      tts_pkg::tts_state_e st;
      logic [31:0] tmr;     // Conversion or write timer
      tts_pkg::tts_trip_s trip;
      logic        dq;
      logic        dq_oe;
   } tts_sys_s;
   // Nonvolatile words start at factory content; reset leaves them alone
   tts_sys_s s_r = '{up: `TTS_UPPER_FACT, lo: `TTS_LOWER_FACT, cfg_lo: `TTS_CFG_LO_FACT,
                     st: tts_pkg::TTS_IDLE, default: '0};
   tts_sys_s s_nxt;
   logic [11:0] res_mask;   // Resolution mask
   logic [31:0] conv_len;   // Conversion length for resolution
   logic [7:0]  cfg_word;
   //--------------------------------------------------------------
   // Resolution decode
   //--------------------------------------------------------------
   always_comb begin
      case (s_r.cfg_lo[`TTS_CFG_RES_LSB +: 2])
         2'h0: begin res_mask = 12'hff8; conv_len = 32'(CONV_CYC / 8); end
         2'h1: begin res_mask = 12'hffc; conv_len = 32'(CONV_CYC / 4); end
         2'h2: begin res_mask = 12'hffe; conv_len = 32'(CONV_CYC / 2); end
         default: begin res_mask = 12'hfff; conv_len = 32'(CONV_CYC); end
      endcase
      cfg_word = {s_r.cfg_hi, s_r.cfg_lo};
   end
   //--------------------------------------------------------------
   // System next state
   //--------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.tog_s = {s_r.tog_s[1:0], lk_r.tog};
      s_nxt.en_s  = {s_r.en_s[0], link_rst_n_i};
      s_nxt.clk_s = {s_r.clk_s[0], serial_clock_convert_i};
      s_nxt.oe_s  = {s_r.oe_s[0], dq_en_r};
      s_nxt.do_s  = {s_r.do_s[0], dq_out_r};
      s_nxt.clk_d = s_r.clk_s[1];
      s_nxt.dq    = s_r.do_s[1];
      s_nxt.dq_oe = s_r.oe_s[1];
      if (!s_r.en_s[1]) begin
         s_nxt.seen = 1'b0;
      end
      // Stand-alone: idle link, convert pin low starts conversions
      if (s_r.cfg_lo[`TTS_CFG_SA_BIT] && !s_r.en_s[1]) begin
         s_nxt.run = !s_r.clk_s[1];
      end
      // Frame events
      if (s_r.tog_s[2] != s_r.tog_s[1]) begin
         if (!s_r.seen) begin
            s_nxt.seen = 1'b1;
            case (lk_r.cmd_h)
               `TTS_CMD_START: s_nxt.run = 1'b1;
               `TTS_CMD_STOP:  s_nxt.run = 1'b0;
               default: ;
            endcase
         end else if (s_r.st != tts_pkg::TTS_NVW) begin
            s_nxt.seen = 1'b0;
            case (lk_r.cmd_h)
               `TTS_CMD_WR_UP: begin s_nxt.up = lk_r.dat_h; s_nxt.st = tts_pkg::TTS_NVW;
                  s_nxt.tmr = 32'(NVW_CYC); end
               `TTS_CMD_WR_LO: begin s_nxt.lo = lk_r.dat_h; s_nxt.st = tts_pkg::TTS_NVW;
                  s_nxt.tmr = 32'(NVW_CYC); end
               `TTS_CMD_WR_CFG: begin s_nxt.cfg_lo = lk_r.dat_h[3:0];
                  s_nxt.cfg_hi[`TTS_CFG_NVB_BIT - 4] = 1'b1;
                  s_nxt.st = tts_pkg::TTS_NVW; s_nxt.tmr = 32'(NVW_CYC); end
               default: ;
            endcase
         end
      end
      // Conversion and write sequencer
      case (s_r.st)
         tts_pkg::TTS_IDLE: begin
            if (s_r.run) begin
               s_nxt.st  = tts_pkg::TTS_CONV;
               s_nxt.tmr = conv_len;
            end
         end
         tts_pkg::TTS_CONV: begin
            if (s_r.tmr <= 32'h1) begin
               s_nxt.temp = sense_i & res_mask;
               s_nxt.cfg_hi[`TTS_CFG_DONE_BIT - 4] = 1'b1;
               s_nxt.st = tts_pkg::TTS_IDLE;
            end else begin
               s_nxt.tmr = s_r.tmr - 32'h1;
            end
         end
         tts_pkg::TTS_NVW: begin
            if (s_r.tmr <= 32'h1) begin
               s_nxt.cfg_hi[`TTS_CFG_NVB_BIT - 4] = 1'b0;
               s_nxt.st = tts_pkg::TTS_IDLE;
            end else begin
               s_nxt.tmr = s_r.tmr - 32'h1;
            end
         end
         default: s_nxt.st = tts_pkg::TTS_IDLE;
      endcase
      // Thermostat outputs, signed compares
      s_nxt.trip.upper = $signed(s_r.temp) >= $signed(s_r.up);
      s_nxt.trip.lower = $signed(s_r.temp) <= $signed(s_r.lo);
      if ($signed(s_r.temp) >= $signed(s_r.up)) begin
         s_nxt.trip.comb = 1'b1;
      end else if ($signed(s_r.temp) <= $signed(s_r.lo)) begin
         s_nxt.trip.comb = 1'b0;
      end
   end
   //--------------------------------------------------------------
   // System registers; nonvolatile words survive reset
   //--------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
         s_r.up <= s_nxt.up;
         s_r.lo <= s_nxt.lo;
         s_r.cfg_lo <= s_nxt.cfg_lo;
         s_r.temp <= `TTS_TEMP_RST;
         s_r.cfg_hi <= `TTS_CFG_HI_RST;
         s_r.run <= s_nxt.cfg_lo[`TTS_CFG_SA_BIT];
         s_r.st <= tts_pkg::TTS_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end
   // Shadows updated in system domain; link reads them only mid-frame
   always_ff @(posedge sys_clk_i) begin
      if (!s_r.en_s[1]) begin
         shd_temp_r <= s_r.temp;
         shd_up_r   <= s_r.up;
         shd_lo_r   <= s_r.lo;
         shd_cfg_r  <= cfg_word;
      end
   end
   // Outputs straight from flops, except busy_o, decoded from the state flops
   always_comb begin
      trip_upper_o = s_r.trip.upper;
      trip_lower_o = s_r.trip.lower;
      trip_comb_o  = s_r.trip.comb;
      dq_o         = s_r.dq;
      dq_oe_o      = s_r.dq_oe;
      busy_o       = s_r.st != tts_pkg::TTS_IDLE;
   end
endmodule : tts_core
`default_nettype wire

//--- sim/tts_core_monitor.sv
// Port checker for the thermometer and thermostat core
`timescale 1ns/10ps
`default_nettype none
module tts_core_monitor #(
   parameter int CONV_CYC = 100, // Conversion cycles
   parameter int NVW_CYC  = 50   // Nonvolatile write cycles
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic link_rst_n_i,
   input wire logic dq_oe_o,
   input wire logic trip_upper_o,
   input wire logic trip_lower_o,
   input wire logic trip_comb_o,
   input wire logic busy_o
);
   // ----------------
   // Helpers
   // ----------------
   logic [15:0] busy_cnt_r; // Length of current busy run
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Counts busy cycles, clears when idle
   always_ff @(posedge sys_clk_i) begin
      busy_cnt_r <= (!rst_n_i || !busy_o) ? 16'h0000 : busy_cnt_r + 16'h0001;
   end
   sequence s_link_idle;
      !link_rst_n_i [*4];
   endsequence
   sequence s_mid_twice;
      (!trip_upper_o && !trip_lower_o) ##1 (!trip_upper_o && !trip_lower_o);
   endsequence
   // ----------------
   // Assertions
   // ----------------
   a_comb_upper: assert property (trip_upper_o |-> trip_comb_o)
      else $error("combined output low with upper trip");
   a_comb_lower: assert property (trip_lower_o |-> !trip_comb_o)
      else $error("combined output high with lower trip");
   a_comb_hold_mid: assert property (s_mid_twice |-> $stable(trip_comb_o))
      else $error("combined output moved between thresholds");
   a_dq_released: assert property (s_link_idle |-> !dq_oe_o)
      else $error("data line driven outside a frame");
   a_oe_in_frame: assert property ($rose(dq_oe_o) |-> link_rst_n_i)
      else $error("data drive started with link closed");
   a_reset_idle: assert property ($rose(rst_n_i) |-> !busy_o && !dq_oe_o)
      else $error("not idle after reset");
   a_busy_min_run: assert property ($rose(busy_o) |-> busy_o [*8])
      else $error("busy run too short");
   a_busy_bound: assert property (busy_cnt_r <= CONV_CYC + NVW_CYC + 16)
      else $error("busy run too long");
endmodule : tts_core_monitor
bind tts_core tts_core_monitor #(.CONV_CYC(CONV_CYC), .NVW_CYC(NVW_CYC)) tts_core_monitor_i (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link_rst_n_i(link_rst_n_i),
   .dq_oe_o(dq_oe_o), .trip_upper_o(trip_upper_o), .trip_lower_o(trip_lower_o),
   .trip_comb_o(trip_comb_o), .busy_o(busy_o));
`default_nettype wire

//--- sim/tts_host_model.sv
// Host model driving the three-wire link
`timescale 1ns/10ps
`default_nettype none
module tts_host_model (
   input  wire logic sys_clk_i,    // System clock
   input  wire logic dev_dq_i,     // Device read data
   input  wire logic dev_oe_i,     // Device drive enable
   output logic      sclk_o,       // Link clock, still outside frames
   output logic      link_rst_n_o, // Frame enable
   output logic      dq_line_o     // Resolved data line
);
   logic drv_r  = 1'b0; // Host drives the line
   logic bit_r  = 1'b0; // Host bit value
   logic last_r = 1'b0; // Last line level
   initial sclk_o = 1'b0;
   // Clean falling edge clears the link logic before the first frame
   initial begin
      link_rst_n_o = 1'b1;
      #1 link_rst_n_o = 1'b0;
   end
   // Released line shows a toggling pattern
   assign dq_line_o = dev_oe_i ? dev_dq_i : (drv_r ? bit_r : ~last_r);
   always @(posedge sys_clk_i) last_r <= dq_line_o;
   // One frame: command LSB first, then 12-bit word
   task automatic xfer(input logic [7:0] cmd, input logic [11:0] wd, output logic [11:0] rd);
      logic [19:0] w;
      w = {wd, cmd};
      rd = 12'h000;
      #3 link_rst_n_o = 1'b1;
      for (int i = 0; i < 20; i++) begin
         drv_r = !(i > 7 && cmd[7]);
         bit_r = w[i];
         #6 sclk_o = 1'b1;
         #6 sclk_o = 1'b0;
         #40 if (i > 6 && i < 19) rd[i - 7] = dev_dq_i;
      end
      drv_r = 1'b0;
      #6 link_rst_n_o = 1'b0;
      #40;
   endtask : xfer
endmodule : tts_host_model
`default_nettype wire

//--- sim/tts_core_tb_top.sv
// Testbench for the thermometer and thermostat core
`include "tts_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tts_core_tb_top;
   logic        sys_clk_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic [11:0] sense_i   = 12'h000;
   logic        sclk, lrst_n, dq_line, dq_o, dq_oe, tu, tl, tc, busy;
   logic [11:0] rd;
   logic [14:0] tv [0:5] = '{{12'h200, 3'b101}, {12'h160, 3'b001}, {12'h140, 3'b010},
                             {12'h170, 3'b000}, {12'h190, 3'b101}, {12'hc40, 3'b010}};
   int          n_errors   = 0;
   int          n_compared = 0;
   initial forever #4 sys_clk_i = ~sys_clk_i;
   tts_core #(.CONV_CYC(300), .NVW_CYC(400)) tts_core_i (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i), .serial_clock_convert_i(sclk), .link_rst_n_i(lrst_n),
      .dq_i(dq_line), .dq_o(dq_o), .dq_oe_o(dq_oe), .sense_i(sense_i), .trip_upper_o(tu),
      .trip_lower_o(tl), .trip_comb_o(tc), .busy_o(busy));
   tts_host_model tts_host_model_i (.sys_clk_i(sys_clk_i), .dev_dq_i(dq_o),
      .dev_oe_i(dq_oe), .sclk_o(sclk), .link_rst_n_o(lrst_n), .dq_line_o(dq_line));
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask : chk
   task wait_busy(input logic lvl, input int lim);
      for (int i = 0; i <= lim; i++) begin
         @(negedge sys_clk_i);
         if (busy === lvl) return;
      end
      $display("MISMATCH busy expected %b seen %b", lvl, busy);
      n_errors++;
      conclude();
   endtask : wait_busy
   task rdw(input logic [7:0] cmd, input logic [11:0] exp, input string what);
      tts_host_model_i.xfer(cmd, 12'h000, rd);
      chk(what, exp, rd);
   endtask : rdw
   task wr(input logic [7:0] cmd, input logic [11:0] d);
      tts_host_model_i.xfer(cmd, d, rd);
      wait_busy(1'b1, 30);
      wait_busy(1'b0, 410);
   endtask : wr
   task conv;
      tts_host_model_i.xfer(`TTS_CMD_START, 12'h000, rd);
      wait_busy(1'b1, 30);
      tts_host_model_i.xfer(`TTS_CMD_STOP, 12'h000, rd);
      wait_busy(1'b0, 310);
      repeat (2) @(negedge sys_clk_i);
   endtask : conv
   task rst;
      @(negedge sys_clk_i);
      rst_n_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
   endtask : rst
   // Main sequence
   initial begin
      rst();
      repeat (2) @(negedge sys_clk_i);
      rdw(`TTS_CMD_RD_TEMP, `TTS_TEMP_RST, "temp");
      rdw(`TTS_CMD_RD_UP, `TTS_UPPER_FACT, "upper");
      rdw(`TTS_CMD_RD_LO, `TTS_LOWER_FACT, "lower");
      rdw(`TTS_CMD_RD_CFG, 12'h080, "cfg");
      $display("test reset values done");
      tts_host_model_i.xfer(`TTS_CMD_WR_UP, 12'h190, rd);
      tts_host_model_i.xfer(`TTS_CMD_WR_UP, 12'h7ff, rd);
      wait_busy(1'b0, 410);
      wr(`TTS_CMD_WR_LO, 12'h140);
      rdw(`TTS_CMD_RD_UP, 12'h190, "upper");
      rdw(`TTS_CMD_RD_LO, 12'h140, "lower");
      $display("test threshold writes done");
      @(negedge sys_clk_i);
      sense_i = 12'h1ab;
      for (int r = 0; r < 4; r++) begin
         wr(`TTS_CMD_WR_CFG, 12'(r << 2));
         conv();
         rdw(`TTS_CMD_RD_TEMP, 12'h1ab & (12'hfff << (3 - r)), "temp");
      end
      $display("test resolution done");
      foreach (tv[k]) begin
         sense_i = tv[k][14:3];
         conv();
         chk("trips", {9'h000, tv[k][2:0]}, {9'h000, tu, tl, tc});
      end
      $display("test thermostat done");
      rst();
      rdw(`TTS_CMD_RD_CFG, 12'h08c, "cfg");
      rdw(`TTS_CMD_RD_UP, 12'h190, "upper");
      rdw(`TTS_CMD_RD_TEMP, `TTS_TEMP_RST, "temp");
      wr(`TTS_CMD_WR_CFG, 12'h00d);
      rst();
      wait_busy(1'b1, 30);
      $display("test stand-alone done");
      conclude();
   end
endmodule : tts_core_tb_top
`default_nettype wire
